/* rtl/rss_pkg.sv */
// Constants and types shared by the reset and strap sequencer
package rss_pkg;
  // Width of the strap option bus
  localparam int unsigned STRAP_W = 8;
  // Clock rate in kHz, period 10 ns
  localparam int unsigned CLK_KHZ = 100000;
  // Wait-state count before bus start; from reset-out release to the
  // first bus enable takes this plus three cycles (release, run, flop)
  localparam logic [3:0] BUS_START_CYC = 4'h4;
  // Delay from first PCI activity to ISA activity in ISA mode
  localparam logic [3:0] ISA_AFTER_PCI_CYC = 4'h4;
  // Open-loop PCI PLL rate during reset, in kHz
  localparam int unsigned PLL_OPEN_KHZ = 250;
  // Half period of the open-loop PLL clock in system clocks
  localparam int unsigned PLL_HALF_CYC = CLK_KHZ / (2 * PLL_OPEN_KHZ);
  // Counter width for the open-loop divider
  localparam int unsigned PLL_CNT_W = 8;
  // Reset value of the latched strap configuration
  localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;
  // Strap bit that selects local bus mode when high
  localparam int unsigned STRAP_LB_BIT = 0;
  // Sequencer states
  typedef enum logic [2:0] {
    RSS_HOLD,
    RSS_LATCH,
    RSS_RELEASE,
    RSS_WAIT,
    RSS_RUN
  } rss_state_t;
endpackage

/* rtl/rss_seq.sv */
// Cold and warm reset sequencer with strap sampling and bus start ordering
// Notes on behaviour
// - Sample straps every cycle while reset held low
// - Bus starts a few cycles after release
// - ISA mode: PCI activity precedes ISA activity
// - Local bus mode: no PCI, flash first
// - Warm reset follows the same sequence
// - PCI PLL open loop, slow, during reset
`timescale 1ns/10ps
module rss_seq (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Board reset source and strap pins
  input wire logic system_reset_in_n,
  input wire logic [rss_pkg::STRAP_W-1:0] strap_i,
  // Reset output and latched configuration
  output logic system_reset_out_n,
  output logic [rss_pkg::STRAP_W-1:0] strap_cfg_o,
  // Bus start-up enables
  output logic pci_en_o,
  output logic isa_en_o,
  output logic flash_en_o,
  // PCI PLL control
  output logic pll_open_loop_o,
  output logic pll_slow_clk_o
);
  import rss_pkg::*;

  // Sequencer state
  rss_state_t state_ff, nxt_state;
  // Straps sampled while reset input is low
  logic [STRAP_W-1:0] strap_smp_ff;
  // Straps latched into configuration
  logic [STRAP_W-1:0] strap_cfg_ff;
  // Cycle counter for start-up delays
  logic [3:0] cnt_ff;
  // Registered outputs
  logic rst_out_ff, pci_ff, isa_ff, flash_ff;
  // Open-loop divider
  logic [PLL_CNT_W-1:0] pll_cnt_ff;
  logic pll_clk_ff;

  // Decoded conditions
  wire in_reset = ~system_reset_in_n;
  wire local_mode = strap_cfg_ff[STRAP_LB_BIT];
  wire cnt_done = (cnt_ff == BUS_START_CYC);
  wire isa_done = (cnt_ff == ISA_AFTER_PCI_CYC);
  wire pll_wrap = (pll_cnt_ff == PLL_CNT_W'(PLL_HALF_CYC - 1));

  // Next state; any low on the reset input restarts the sequence,
  // which makes a warm reset identical to a cold one
  always_comb begin
    nxt_state = state_ff;
    if (in_reset) begin
      nxt_state = RSS_HOLD;
    end else begin
      unique case (state_ff)
        RSS_HOLD: nxt_state = RSS_LATCH;
        RSS_LATCH: nxt_state = RSS_RELEASE;
        RSS_RELEASE: nxt_state = RSS_WAIT;
        RSS_WAIT: begin
          if (cnt_done) begin
            nxt_state = RSS_RUN;
          end
        end
        RSS_RUN: nxt_state = RSS_RUN;
        default: nxt_state = RSS_HOLD;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= RSS_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Continuous strap sampling while the reset input is low
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_smp_ff <= STRAP_RST;
    end else if (in_reset) begin
      strap_smp_ff <= strap_i;
    end
  end

  // Latch the sampled straps once, after the reset input rises;
  // the board keeps the pins stable so the last sample is valid
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cfg_ff <= STRAP_RST;
    end else if (state_ff == RSS_LATCH) begin
      strap_cfg_ff <= strap_smp_ff;
    end
  end

  // Reset output: high only from the release state onward
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_out_ff <= 1'b0;
    end else begin
      rst_out_ff <= (nxt_state == RSS_RELEASE) || (nxt_state == RSS_WAIT)
        || (nxt_state == RSS_RUN);
    end
  end

  // Start-up counter, cleared on entering wait and on entering run
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 4'h0;
    end else if (state_ff != nxt_state) begin
      cnt_ff <= 4'h0;
    end else if (!cnt_done || state_ff == RSS_RUN && !isa_done) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // Bus enables: PCI first, ISA later, flash only in local bus mode
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pci_ff <= 1'b0;
      isa_ff <= 1'b0;
      flash_ff <= 1'b0;
    end else if (in_reset || state_ff != RSS_RUN) begin
      pci_ff <= 1'b0;
      isa_ff <= 1'b0;
      flash_ff <= 1'b0;
    end else if (local_mode) begin
      pci_ff <= 1'b0;
      isa_ff <= 1'b0;
      flash_ff <= 1'b1;
    end else begin
      pci_ff <= 1'b1;
      isa_ff <= pci_ff && (isa_ff || isa_done);
      flash_ff <= 1'b0;
    end
  end

  // Open-loop PLL divider runs only while the reset input is low;
  // a coarse rate is fine since nothing is clocked from it in reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_cnt_ff <= '0;
      pll_clk_ff <= 1'b0;
    end else if (!in_reset) begin
      pll_cnt_ff <= '0;
      pll_clk_ff <= 1'b0;
    end else if (pll_wrap) begin
      pll_cnt_ff <= '0;
      pll_clk_ff <= ~pll_clk_ff;
    end else begin
      pll_cnt_ff <= pll_cnt_ff + PLL_CNT_W'(1);
    end
  end

  // Output drives
  assign system_reset_out_n = rst_out_ff;
  assign strap_cfg_o = strap_cfg_ff;
  assign pci_en_o = pci_ff;
  assign isa_en_o = isa_ff;
  assign flash_en_o = flash_ff;
  assign pll_open_loop_o = in_reset;
  assign pll_slow_clk_o = pll_clk_ff;

  // Checks
  // Release of the reset output, seen at the edge after its launch
  sequence s_release;
    $rose(system_reset_out_n);
  endsequence

  // PCI coming up while the latched straps select ISA mode
  sequence s_pci_up;
    $rose(pci_en_o) && !local_mode;
  endsequence

  // ISA held off for the gap of four cycles, then enabled; the count
  // must follow the ISA gap constant if that is ever changed
  sequence s_isa_gap;
    (!isa_en_o)[*4] ##1 isa_en_o;
  endsequence

  a_strap_sample: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    in_reset |=> strap_smp_ff == $past(strap_i))
    else $error("straps not sampled during reset");
  a_out_low_reset: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    in_reset |=> !system_reset_out_n)
    else $error("reset out high during reset in");
  // The latch state is the cycle just before the release is launched
  a_latch_before_rel: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_release |-> $past(state_ff == RSS_LATCH))
    else $error("reset out released without latch");
  a_cfg_at_release: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_release |-> strap_cfg_ff == $past(strap_smp_ff))
    else $error("straps not latched at release");
  a_no_bus_early: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_release |-> (!(pci_en_o || flash_en_o))[*4])
    else $error("bus active too soon after release");
  a_bus_starts: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_release ##1 !in_reset[*8] |-> (pci_en_o || flash_en_o))
    else $error("bus did not start");
  a_pci_before_isa: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    isa_en_o |-> pci_en_o && !local_mode)
    else $error("isa active without pci");
  // A warm reset in the gap aborts the attempt rather than failing it
  a_isa_after_pci: assert property (
    @(posedge clock_i) disable iff (!rst_n_i || in_reset)
    s_pci_up |-> s_isa_gap)
    else $error("isa gap after pci wrong");
  a_local_no_pci: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    local_mode |-> !pci_en_o)
    else $error("pci active in local bus mode");
  a_flash_local: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    flash_en_o |-> local_mode && !pci_en_o && !isa_en_o)
    else $error("flash active outside local bus mode");
  a_warm_same: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $fell(system_reset_in_n) |=> state_ff == RSS_HOLD && !pci_en_o)
    else $error("warm reset did not restart sequence");
  a_pll_open: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !in_reset |=> !pll_slow_clk_o)
    else $error("pll slow clock outside reset");
endmodule // rss_seq

/* tb/rss_board.sv */
// Board reset supervisor and strap resistor model
`timescale 1ns/10ps
module rss_board (
  // Clock and device reset output
  input wire logic clock_i,
  input wire logic system_reset_out_n,
  // Reset source and strap pins
  output logic system_reset_in_n,
  output logic [rss_pkg::STRAP_W-1:0] strap_o
);
  import rss_pkg::*;
  // Supervisor holds reset from power-up until commanded
  initial begin
    system_reset_in_n = 1'b0;
    strap_o = 8'h00;
  end
  // One clean pulse; straps only move while reset is low
  task automatic pulse(input int len, input logic [7:0] a, b);
    int n;
    @(posedge clock_i) #1;
    system_reset_in_n = 1'b0;
    strap_o = a;
    repeat (len / 2) @(posedge clock_i);
    #1 strap_o = b;
    // Long enough for supplies, PLLs and straps to settle
    repeat (len / 2) @(posedge clock_i);
    #1 system_reset_in_n = 1'b1;
    n = 0;
    // Straps stay put until the device leaves reset
    while (system_reset_out_n !== 1'b1 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
  endtask
endmodule // rss_board

/* tb/tb_cold_warm_reset_strap_sequencer.sv */
// Self-checking bench for the reset and strap sequencer
`timescale 1ns/10ps
module tb_cold_warm_reset_strap_sequencer;
  import rss_pkg::*;
  logic clock_i, rst_n_i, in_n, out_n, pci, isa, fl, pll_ol, pll_ck;
  logic [STRAP_W-1:0] strap, cfg;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Release to bus enable: release state, wait count, run entry, flop
  localparam logic [7:0] START_EXP = 8'(BUS_START_CYC) + 8'h03;
  // Device and board model
  rss_seq u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .system_reset_in_n(in_n), .strap_i(strap),
    .system_reset_out_n(out_n), .strap_cfg_o(cfg), .pci_en_o(pci),
    .isa_en_o(isa), .flash_en_o(fl), .pll_open_loop_o(pll_ol),
    .pll_slow_clk_o(pll_ck));
  rss_board u_brd (.clock_i(clock_i), .system_reset_out_n(out_n),
    .system_reset_in_n(in_n), .strap_o(strap));
  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard: the run needs about 2050 cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  // Pulse reset, check reset-time outputs, count cycles to bus start
  task automatic pulse_chk(input logic [7:0] a, b, output int n);
    logic ck0;
    fork
      u_brd.pulse(1000, a, b);
    join_none
    repeat (4) @(posedge clock_i);
    #2 ck0 = pll_ck;
    chk("pll_open", 8'h01, pll_ol);
    chk("rst_out", 8'h00, out_n);
    // One half period later the slow clock must have flipped
    repeat (200) @(posedge clock_i);
    #2 chk("pll_clk", {7'h00, !ck0}, pll_ck);
    n = 0;
    while (out_n !== 1'b1 && n < 1000) begin
      @(posedge clock_i);
      #2 n++;
    end
    chk("strap_cfg", b, cfg);
    n = 0;
    while (pci !== 1'b1 && fl !== 1'b1 && n < 20) begin
      @(posedge clock_i);
      #2 n++;
    end
  endtask
  // Cold reset in ISA mode, straps moved while reset is low
  task automatic cold_isa();
    int n;
    pulse_chk(8'h5B, 8'hA6, n);
    chk("bus_delay", START_EXP, 8'(n));
    chk("pci_first", 8'h02, {fl, pci, isa});
    // ISA follows PCI after the package gap, never earlier
    repeat (int'(ISA_AFTER_PCI_CYC) - 1) @(posedge clock_i);
    #2 chk("isa_early", 8'h00, isa);
    @(posedge clock_i);
    #2 chk("isa_on", 8'h01, isa);
  endtask
  // Warm reset into local bus mode: flash only, PCI stays idle
  task automatic warm_local();
    int n;
    pulse_chk(8'hA6, 8'h5B, n);
    chk("bus_delay", START_EXP, 8'(n));
    repeat (10) begin
      chk("lb_enables", 8'h04, {fl, pci, isa});
      @(posedge clock_i);
      #2;
    end
  endtask
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    repeat (20) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    cold_isa();
    warm_local();
    give_verdict();
  end
endmodule // tb_cold_warm_reset_strap_sequencer
